// File: rtl/cp_mode_pkg.sv
// constants for the charge-pump mode and timing control block
package cp_mode_pkg;

   // register offsets
   localparam logic [7:0] ADDR_CONVERTER_MODE_CONTROL      = 8'h0f;
   localparam logic [7:0] ADDR_PHASE_AND_TRANSITION_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_PRECHARGE_TIMING_CONTROL    = 8'h11;

   // reset values
   localparam logic [7:0] RST_CONVERTER_MODE_CONTROL       = 8'h24;
   localparam logic [7:0] RST_PHASE_AND_TRANSITION_CONTROL  = 8'h24;
   localparam logic [7:0] RST_PRECHARGE_TIMING_CONTROL     = 8'ha9;

   // field positions, converter_mode_control
   localparam int RECOVERY_DEGLITCH_BIT = 7;
   localparam int SPREAD_SPECTRUM_BIT   = 6;
   localparam int FREQ_LSB              = 3;
   localparam int CONVERTER_ENABLE_BIT  = 2;
   localparam int REVERSE_BIT           = 1;
   localparam int TOPOLOGY_BIT          = 0;
   // phase_and_transition_control
   localparam int PHASE_A_LSB           = 6;
   localparam int PHASE_B_LSB           = 4;
   localparam int AUTO_TRANS_EN_BIT     = 3;
   localparam int AUTO_TRANS_THR_LSB    = 0;
   // precharge_timing_control
   localparam int DIAG_TIME_LSB         = 6;
   localparam int SOFT_CURRENT_LSB      = 4;
   localparam int ERR_ON_TIME_LSB       = 2;
   localparam int ERR_OFF_TIME_BIT      = 1;
   localparam int POST_TIMEOUT_BIT      = 0;

   localparam logic [1:0] INPUT_SWITCH_OFF = 2'h0;
   localparam logic [1:0] SOFT_CURRENT_RESERVED = 2'h0;

   // times
   localparam int CLK_MHZ          = 100;
   localparam int DEGLITCH_SHORT_MS = 21;
   localparam int DEGLITCH_LONG_MS  = 100;
   localparam int ERR_OFF_SHORT_MS  = 40;
   localparam int ERR_OFF_LONG_MS   = 80;
   localparam int HALF_MS_US        = 500;
   localparam int HALF_MS_CYCLES    = HALF_MS_US * CLK_MHZ;
   localparam int TICK_W            = 17;
   localparam int MS_W              = 7;
   localparam logic [TICK_W-1:0] HALF_MS_LAST = TICK_W'(HALF_MS_CYCLES - 1);

   typedef enum logic [1:0] {
      MODE_FWD_BYPASS = 2'h0,
      MODE_FWD_HALVING = 2'h1,
      MODE_REV_HALVING = 2'h3,
      MODE_REV_BYPASS  = 2'h2
   } conv_mode_e;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'h0,
      ST_PRECHG  = 2'h1,
      ST_RUN     = 2'h3,
      ST_ERR_OFF = 2'h2
   } conv_state_e;
endpackage

// File: rtl/ms_timer.sv
// half-millisecond tick generator and loadable half-ms countdown
`timescale 1ns/1ps
`default_nettype none
module ms_timer
   import cp_mode_pkg::*;
(
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   // control
   input  wire logic              load_in,
   input  wire logic [8:0]        halves_in,
   // status
   output logic                   done_out,
   output logic                   busy_out
);
   typedef struct packed {
      logic [TICK_W-1:0] tick;
      logic [8:0]        left;
      logic              busy;
      logic              done;
   } tmr_s;

   tmr_s r;
   tmr_s next_r;

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (load_in) begin
         next_r.tick = '0;
         next_r.left = halves_in;
         next_r.busy = 1'b1;
      end else if (r.busy) begin
         if (r.tick == HALF_MS_LAST) begin
            next_r.tick = '0;
            if (r.left <= 9'h001) begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
               next_r.left = '0;
            end else begin
               next_r.left = r.left - 9'h001;
            end
         end else begin
            next_r.tick = r.tick + TICK_W'(1);
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign done_out = r.done;
   assign busy_out = r.busy;
endmodule
`default_nettype wire

// File: rtl/cp_mode_ctrl.sv
// converter mode, phase and pre-charge timing control registers with sequencing
//
// Contract
// (RQ1) bypass overvoltage recovery deglitch: 21 ms if bit 0, 100 ms if 1.
// (RQ2) spread-spectrum bit 1 dithers switching frequency; 0 keeps it fixed.
// (RQ3) frequency field picks 300..1500 kHz code table; resets to 500 kHz.
// (RQ4) converter enable resets to 1; 0 means standby, 1 means enabled.
// (RQ5) watchdog timeout keeps enable only in bypass with post-timeout bit 1.
// (RQ6) reverse bit selects reverse halving or reverse bypass per topology bit.
// (RQ7) topology bit: 0 bypass, 1 divide-by-two.
// (RQ8) phase A angle field: 0, 90, 180, 270 degrees; reset 00.
// (RQ9) phase B angle field same encoding; reset 10 (180 degrees).
// (RQ10) host programs phase angles only before enabling, never while running.
// (RQ11) host sets phase A 00 single or master, 01 parallel slave.
// (RQ12) host sets phase B 10 single or master, 11 parallel slave.
// (RQ13) auto-transition enable bit switches bypass and halving automatically; code follows the threshold only while not running.
// (RQ14) threshold field 9 V to 11.5 V in half-volt steps, 110/111 give 12 V.
// (RQ15) diagnosis time 0.5/1/2/4 ms; alone sets reverse halving pre-charge.
// (RQ16) forward halving pre-charge equals diagnosis time plus error on-time.
// (RQ17) error on-time 0.5/1/2/4 ms; alone sets bypass pre-charge time.
// (RQ18) soft-start current 330/500/660 mA; code 00 reserved.
// (RQ19) bypass output short error waits 40 ms or 80 ms before turning off; code turns off at once, then stays off 40 or 80 ms.
// (RQ20) post-timeout bit 0: timeout gives standby and input switch off.
// (RQ21) post-timeout bit 1 in bypass: timeout leaves converter running.
// (RQ22) input switch control 00 turns the input blocking transistor off.
// (RQ23) register reset restores all defaults; watchdog touches only enable.
`timescale 1ns/1ps
`default_nettype none
module cp_mode_ctrl
   import cp_mode_pkg::*;
(
   // clock and resets
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  wire logic              reg_reset_in,
   input  wire logic              watchdog_timeout_in,
   // register port
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   output logic      [7:0]        reg_rdata_out,
   output logic                   reg_hit_out,
   // analog status
   input  wire logic              overvoltage_fault_in,
   input  wire logic              output_short_in,
   input  wire logic              above_threshold_in,
   input  wire logic [1:0]        input_switch_control_in,
   // converter controls
   output logic                   converter_on_out,
   output logic                   precharge_out,
   output logic [1:0]             conv_mode_out,
   output logic [2:0]             switching_frequency_sel_out,
   output logic                   spread_spectrum_out,
   output logic [1:0]             phase_a_angle_out,
   output logic [1:0]             phase_b_angle_out,
   output logic [2:0]             auto_transition_threshold_out,
   output logic [1:0]             soft_start_current_sel_out,
   output logic                   soft_start_current_bad_out,
   output logic                   input_switch_clear_out,
   output logic                   input_switch_off_out,
   output logic                   recovery_pending_out
);
   typedef struct packed {
      logic [7:0]  mode_ctl;
      logic [7:0]  phase_ctl;
      logic [7:0]  timing_ctl;
      logic        auto_halving;
      conv_state_e state;
      logic        ovp_wait;
      logic [7:0]  rdata;
      logic        hit;
      logic        on;
      logic        prechg;
      logic [1:0]  mode;
      logic [2:0]  freq;
      logic        ss;
      logic [1:0]  pha;
      logic [1:0]  phb;
      logic [2:0]  thr;
      logic [1:0]  cur;
      logic        cur_bad;
      logic        sw_clear;
      logic        sw_off;
   } ctl_s;

   ctl_s        r;
   ctl_s        next_r;
   logic        tmr_load;
   logic [8:0]  tmr_halves;
   logic        tmr_done;
   logic        tmr_busy;

   // 2 bit code to half-ms units: 1, 2, 4, 8
   function automatic logic [8:0] code_halves(input logic [1:0] code);
      code_halves = 9'h001 << code;
   endfunction

   // millisecond figure to half-ms units
   function automatic logic [8:0] ms_halves(input int ms);
      ms_halves = 9'(ms * 2);
   endfunction

   ms_timer u_timer (
      .clk_in    (clk_in),
      .srst_in   (srst_in),
      .load_in   (tmr_load),
      .halves_in (tmr_halves),
      .done_out  (tmr_done),
      .busy_out  (tmr_busy)
   );

   logic       topo;
   logic       rev;
   logic       bypass;
   logic       enable;
   logic [1:0] diag;
   logic [1:0] on_t;
   logic [8:0] prechg_halves;

   always_comb begin
      topo   = r.mode_ctl[TOPOLOGY_BIT] | (r.phase_ctl[AUTO_TRANS_EN_BIT] & r.auto_halving); // [RQ7] [RQ13]
      rev    = r.mode_ctl[REVERSE_BIT];
      bypass = ~topo;
      enable = r.mode_ctl[CONVERTER_ENABLE_BIT];
      diag   = r.timing_ctl[DIAG_TIME_LSB +: 2];
      on_t   = r.timing_ctl[ERR_ON_TIME_LSB +: 2];
      if (!topo) begin
         prechg_halves = code_halves(on_t); // [RQ17]
      end else if (rev) begin
         prechg_halves = code_halves(diag); // [RQ15]
      end else begin
         prechg_halves = code_halves(diag) + code_halves(on_t); // [RQ16]
      end
   end

   always_comb begin
      next_r = r;
      tmr_load = 1'b0;
      tmr_halves = '0;
      next_r.sw_clear = 1'b0;
      next_r.hit = 1'b0;

      // register access; register reset restores every default
      if (reg_reset_in) begin
         next_r.mode_ctl   = RST_CONVERTER_MODE_CONTROL; // [RQ23]
         next_r.phase_ctl  = RST_PHASE_AND_TRANSITION_CONTROL;
         next_r.timing_ctl = RST_PRECHARGE_TIMING_CONTROL;
      end else if (reg_wr_in) begin
         if (reg_addr_in == ADDR_CONVERTER_MODE_CONTROL) begin
            next_r.mode_ctl = reg_wdata_in;
         end else if (reg_addr_in == ADDR_PHASE_AND_TRANSITION_CONTROL) begin
            // phase register written in any state; angle outputs take it only while idle; host keeps this order anyway [RQ10]
            next_r.phase_ctl = reg_wdata_in;
         end else if (reg_addr_in == ADDR_PRECHARGE_TIMING_CONTROL) begin
            next_r.timing_ctl = reg_wdata_in;
         end
      end

      // watchdog timeout overrides a write in the same cycle
      if (watchdog_timeout_in && !reg_reset_in) begin
         if (!(bypass && r.timing_ctl[POST_TIMEOUT_BIT])) begin
            next_r.mode_ctl[CONVERTER_ENABLE_BIT] = 1'b0; // [RQ5] [RQ20]
         end // else enable and mode held [RQ21]
         if (!r.timing_ctl[POST_TIMEOUT_BIT]) begin
            next_r.sw_clear = 1'b1; // [RQ20]
         end
      end

      if (reg_rd_in) begin
         next_r.hit = 1'b1;
         if (reg_addr_in == ADDR_CONVERTER_MODE_CONTROL) begin
            next_r.rdata = r.mode_ctl;
         end else if (reg_addr_in == ADDR_PHASE_AND_TRANSITION_CONTROL) begin
            next_r.rdata = r.phase_ctl;
         end else if (reg_addr_in == ADDR_PRECHARGE_TIMING_CONTROL) begin
            next_r.rdata = r.timing_ctl;
         end else begin
            next_r.rdata = '0;
            next_r.hit = 1'b0;
         end
      end

      // automatic transition: above threshold favours halving
      if (r.phase_ctl[AUTO_TRANS_EN_BIT] && r.state != ST_RUN) begin
         next_r.auto_halving = above_threshold_in; // [RQ13]
      end else if (!r.phase_ctl[AUTO_TRANS_EN_BIT]) begin
         next_r.auto_halving = 1'b0;
      end

      // sequencer
      case (r.state)
         ST_IDLE: begin
            if (enable && !r.ovp_wait) begin
               tmr_load = 1'b1;
               tmr_halves = prechg_halves;
               next_r.state = ST_PRECHG;
            end
         end
         ST_PRECHG: begin
            if (!enable) begin
               next_r.state = ST_IDLE; // [RQ4]
            end else if (tmr_done) begin
               next_r.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!enable) begin
               next_r.state = ST_IDLE; // [RQ4]
            end else if (bypass && output_short_in) begin
               tmr_load = 1'b1;
               tmr_halves = r.timing_ctl[ERR_OFF_TIME_BIT] ? ms_halves(ERR_OFF_LONG_MS)
                                                            : ms_halves(ERR_OFF_SHORT_MS); // [RQ19]
               next_r.state = ST_ERR_OFF;
            end else if (bypass && overvoltage_fault_in) begin
               // fault drops to idle and waits out the deglitch before restart
               tmr_load = 1'b1;
               tmr_halves = r.mode_ctl[RECOVERY_DEGLITCH_BIT] ? ms_halves(DEGLITCH_LONG_MS)
                                                               : ms_halves(DEGLITCH_SHORT_MS); // [RQ1]
               next_r.ovp_wait = 1'b1;
               next_r.state = ST_IDLE;
            end
         end
         ST_ERR_OFF: begin
            if (!enable || tmr_done) begin
               next_r.state = ST_IDLE; // [RQ19]
            end
         end
         default: next_r.state = ST_IDLE;
      endcase

      // deglitch restarts whenever the fault is seen again
      if (r.ovp_wait) begin
         if (overvoltage_fault_in) begin
            tmr_load = 1'b1;
            tmr_halves = r.mode_ctl[RECOVERY_DEGLITCH_BIT] ? ms_halves(DEGLITCH_LONG_MS)
                                                            : ms_halves(DEGLITCH_SHORT_MS); // [RQ1]
         end else if (tmr_done || !tmr_busy) begin
            next_r.ovp_wait = 1'b0;
         end
      end

      // registered outputs
      next_r.on      = (next_r.state == ST_RUN);
      next_r.prechg  = (next_r.state == ST_PRECHG);
      next_r.mode    = {rev, topo}; // [RQ6]
      next_r.freq    = r.mode_ctl[FREQ_LSB +: 3]; // [RQ3]
      next_r.ss      = r.mode_ctl[SPREAD_SPECTRUM_BIT]; // [RQ2]
      if (r.state == ST_IDLE) begin
         // angles only change while stopped, avoids phase glitches
         next_r.pha = r.phase_ctl[PHASE_A_LSB +: 2]; // [RQ8]
         next_r.phb = r.phase_ctl[PHASE_B_LSB +: 2]; // [RQ9]
      end
      next_r.thr     = r.phase_ctl[AUTO_TRANS_THR_LSB +: 3]; // [RQ14]
      next_r.cur     = r.timing_ctl[SOFT_CURRENT_LSB +: 2]; // [RQ18]
      next_r.cur_bad = (r.timing_ctl[SOFT_CURRENT_LSB +: 2] == SOFT_CURRENT_RESERVED); // [RQ18]
      next_r.sw_off  = (input_switch_control_in == INPUT_SWITCH_OFF); // [RQ22]
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         r <= '0;
         r.mode_ctl   <= RST_CONVERTER_MODE_CONTROL; // [RQ23]
         r.phase_ctl  <= RST_PHASE_AND_TRANSITION_CONTROL;
         r.timing_ctl <= RST_PRECHARGE_TIMING_CONTROL;
         r.state      <= ST_IDLE;
         r.freq       <= RST_CONVERTER_MODE_CONTROL[FREQ_LSB +: 3];
         r.phb        <= RST_PHASE_AND_TRANSITION_CONTROL[PHASE_B_LSB +: 2];
         r.thr        <= RST_PHASE_AND_TRANSITION_CONTROL[AUTO_TRANS_THR_LSB +: 3];
         r.cur        <= RST_PRECHARGE_TIMING_CONTROL[SOFT_CURRENT_LSB +: 2];
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata_out                 = r.rdata;
   assign reg_hit_out                   = r.hit;
   assign converter_on_out              = r.on;
   assign precharge_out                 = r.prechg;
   assign conv_mode_out                 = r.mode;
   assign switching_frequency_sel_out   = r.freq;
   assign spread_spectrum_out           = r.ss;
   assign phase_a_angle_out             = r.pha;
   assign phase_b_angle_out             = r.phb;
   assign auto_transition_threshold_out = r.thr;
   assign soft_start_current_sel_out    = r.cur;
   assign soft_start_current_bad_out    = r.cur_bad;
   assign input_switch_clear_out        = r.sw_clear;
   assign input_switch_off_out          = r.sw_off;
   assign recovery_pending_out          = r.ovp_wait;
endmodule
`default_nettype wire

// File: verification/cp_mode_ctrl_props.sv
// concurrent checks on the converter mode and timing control ports
`timescale 1ns/1ps
`default_nettype none
module cp_mode_ctrl_props
   import cp_mode_pkg::*;
(
   // clock, reset and events
   input wire logic       clk_in,
   input wire logic       srst_in,
   input wire logic       reg_reset_in,
   input wire logic       watchdog_timeout_in,
   // register port
   input wire logic       reg_wr_in,
   input wire logic       reg_rd_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic       reg_hit_out,
   // status and controls
   input wire logic       overvoltage_fault_in,
   input wire logic [1:0] input_switch_control_in,
   input wire logic       converter_on_out,
   input wire logic       precharge_out,
   input wire logic [1:0] conv_mode_out,
   input wire logic [1:0] phase_a_angle_out,
   input wire logic [1:0] phase_b_angle_out,
   input wire logic [1:0] soft_start_current_sel_out,
   input wire logic       soft_start_current_bad_out,
   input wire logic       input_switch_clear_out,
   input wire logic       input_switch_off_out,
   input wire logic       recovery_pending_out
);
   logic mapped;
   assign mapped = (reg_addr_in >= 8'h0f) && (reg_addr_in <= 8'h11);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   chk_read_hit: assert property (reg_rd_in && mapped |=> reg_hit_out)
      else $error("hit missing after mapped read");
   chk_unmapped_zero: assert property (reg_rd_in && !mapped |=> !reg_hit_out && reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   chk_hit_pulse: assert property (!reg_rd_in |=> !reg_hit_out)
      else $error("hit without read");
   chk_write_readback: assert property (
      (reg_wr_in && !reg_reset_in && reg_addr_in == ADDR_PRECHARGE_TIMING_CONTROL)
      ##1 (!reg_wr_in && !reg_reset_in)
      ##1 (reg_rd_in && !reg_wr_in && !reg_reset_in && reg_addr_in == ADDR_PRECHARGE_TIMING_CONTROL)
      |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("timing register readback differs");
   chk_switch_off: assert property (1'b1 |=> input_switch_off_out == ($past(input_switch_control_in) == INPUT_SWITCH_OFF))
      else $error("input switch off flag wrong");
   chk_clear_cause: assert property (!watchdog_timeout_in |=> !input_switch_clear_out)
      else $error("input switch clear without timeout");
   chk_bad_code: assert property (soft_start_current_bad_out == (soft_start_current_sel_out == SOFT_CURRENT_RESERVED))
      else $error("reserved current flag wrong");
   chk_run_after_prechg: assert property ($rose(converter_on_out) |-> $past(precharge_out))
      else $error("converter ran without pre-charge");
   chk_on_excl: assert property (converter_on_out |-> !precharge_out)
      else $error("pre-charge while running");
   chk_phase_frozen: assert property (converter_on_out && $past(converter_on_out)
      |-> $stable(phase_a_angle_out) && $stable(phase_b_angle_out))
      else $error("phase angle moved while running");
   chk_ovp_stop: assert property (converter_on_out && overvoltage_fault_in && !conv_mode_out[0]
      |-> ##[1:4] (!converter_on_out && recovery_pending_out))
      else $error("overvoltage did not stop bypass");
   cover property ($rose(converter_on_out));
   cover property (input_switch_clear_out);
   cover property ($rose(recovery_pending_out));
   cover property (reg_rd_in && !mapped);
endmodule
bind cp_mode_ctrl cp_mode_ctrl_props i_props (
   .clk_in(clk_in), .srst_in(srst_in), .reg_reset_in(reg_reset_in), .watchdog_timeout_in(watchdog_timeout_in),
   .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_rdata_out(reg_rdata_out), .reg_hit_out(reg_hit_out), .overvoltage_fault_in(overvoltage_fault_in),
   .input_switch_control_in(input_switch_control_in), .converter_on_out(converter_on_out),
   .precharge_out(precharge_out), .conv_mode_out(conv_mode_out), .phase_a_angle_out(phase_a_angle_out),
   .phase_b_angle_out(phase_b_angle_out), .soft_start_current_sel_out(soft_start_current_sel_out),
   .soft_start_current_bad_out(soft_start_current_bad_out), .input_switch_clear_out(input_switch_clear_out),
   .input_switch_off_out(input_switch_off_out), .recovery_pending_out(recovery_pending_out)
);
`default_nettype wire

// File: verification/host_reg_model.sv
// host-side model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module host_reg_model (
   // clock
   input  wire logic       clk_in,
   // register port
   output logic            reg_wr_out,
   output logic            reg_rd_out,
   output logic [7:0]      reg_addr_out,
   output logic [7:0]      reg_wdata_out,
   input  wire logic [7:0] reg_rdata_in,
   input  wire logic       reg_hit_in
);
   logic [7:0] last_rdata;
   logic       last_hit;
   initial begin
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      reg_addr_out = 8'h00;
      reg_wdata_out = 8'h00;
   end
   // released lines show the inverse so stale values never look valid
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      reg_wr_out <= 1'b1;
      reg_addr_out <= a;
      reg_wdata_out <= d;
      @(posedge clk_in);
      reg_wr_out <= 1'b0;
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask
   task automatic read_reg(input logic [7:0] a);
      @(posedge clk_in);
      reg_rd_out <= 1'b1;
      reg_addr_out <= a;
      @(posedge clk_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      #1;
      last_rdata = reg_rdata_in;
      last_hit = reg_hit_in;
   endtask
   // callers write this only while the converter is disabled
   function automatic logic [7:0] phase_byte(input logic slave, input logic [3:0] low);
      return {slave ? 4'h7 : 4'h2, low};
   endfunction
endmodule
`default_nettype wire

// File: verification/charge_pump_mode_timing_control_test.sv
// self-checking bench for the converter mode and timing control block
`timescale 1ns/1ps
`default_nettype none
module charge_pump_mode_timing_control_test
   import cp_mode_pkg::*;
;
   logic clk_in, srst_in, reg_reset_in, watchdog_timeout_in, overvoltage_fault, above, oshort;
   logic wr, rd, hit, conv_on, pre, ss, bad, isw_clr, isw_off, rpend, seen;
   logic [7:0] addr, wdata, rdata, d;
   logic [7:0] m [3];
   logic [2:0] freq, thr;
   logic [1:0] isw, mode, pa, pb, cur;
   int err_count, samples_checked, cyc, n;
   cp_mode_ctrl i_dut (.clk_in(clk_in), .srst_in(srst_in), .reg_reset_in(reg_reset_in),
      .watchdog_timeout_in(watchdog_timeout_in), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit), .overvoltage_fault_in(overvoltage_fault),
      .output_short_in(oshort), .above_threshold_in(above), .input_switch_control_in(isw),
      .converter_on_out(conv_on), .precharge_out(pre), .conv_mode_out(mode),
      .switching_frequency_sel_out(freq), .spread_spectrum_out(ss), .phase_a_angle_out(pa),
      .phase_b_angle_out(pb), .auto_transition_threshold_out(thr), .soft_start_current_sel_out(cur),
      .soft_start_current_bad_out(bad), .input_switch_clear_out(isw_clr), .input_switch_off_out(isw_off),
      .recovery_pending_out(rpend));
   host_reg_model i_host (.clk_in(clk_in), .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_hit_in(hit));
   task automatic complete_run();
      if (err_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic wr_reg(input int i, input logic [7:0] v);
      i_host.write_reg(8'h0f + 8'(i), v);
      m[i] = v;
   endtask
   task automatic rd_reg(input int i);
      i_host.read_reg(8'h0f + 8'(i));
      chk("rdata", m[i], i_host.last_rdata);
      chk("hit", 8'h01, 8'(i_host.last_hit));
   endtask
   task automatic outs();
      repeat (2) @(posedge clk_in);
      #1;
      chk("freq", 8'(m[0][5:3]), 8'(freq));
      chk("spread", 8'(m[0][6]), 8'(ss));
      chk("mode", 8'(m[0][1:0]), 8'(mode));
      chk("phase a", 8'(m[1][7:6]), 8'(pa));
      chk("phase b", 8'(m[1][5:4]), 8'(pb));
      chk("threshold", 8'(m[1][2:0]), 8'(thr));
      chk("current", 8'(m[2][5:4]), 8'(cur));
      chk("reserved", 8'(m[2][5:4] == 2'h0), 8'(bad));
   endtask
   task automatic pulse_timeout();
      @(posedge clk_in) watchdog_timeout_in <= 1'b1;
      @(posedge clk_in) watchdog_timeout_in <= 1'b0;
      #1;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // the bypass pre-charge run dominates the cycle count
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         complete_run();
      end
   end
   initial begin
      srst_in = 1'b1;
      reg_reset_in = 1'b0;
      watchdog_timeout_in = 1'b0;
      overvoltage_fault = 1'b0;
      oshort = 1'b0;
      above = 1'b0;
      isw = 2'h1;
      m = '{RST_CONVERTER_MODE_CONTROL, RST_PHASE_AND_TRANSITION_CONTROL, RST_PRECHARGE_TIMING_CONTROL};
      void'($urandom(49));
      repeat (8) @(posedge clk_in);
      srst_in <= 1'b0;
      for (int i = 0; i < 3; i++) rd_reg(i);
      outs();
      i_host.read_reg(8'h12);
      chk("unmapped", 8'h00, i_host.last_rdata);
      chk("unmapped hit", 8'h00, 8'(i_host.last_hit));
      wr_reg(0, 8'h20);
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom);
         if (i % 3 == 0) d = {d[7:3], 1'b0, 2'(i / 3)};
         if (i % 3 == 1) d[3] = 1'b0;
         @(posedge clk_in) isw <= 2'($urandom);
         wr_reg(i % 3, d);
         rd_reg(i % 3);
         outs();
         chk("switch off", 8'(isw == 2'h0), 8'(isw_off));
      end
      wr_reg(0, 8'h20);
      wr_reg(1, i_host.phase_byte(1'b1, 4'hc));
      for (int a = 1; a >= 0; a--) begin
         @(posedge clk_in) above <= a[0];
         repeat (3) @(posedge clk_in);
         #1 chk("auto mode", 8'(a), 8'(mode));
      end
      for (int k = 0; k < 3; k++) begin
         wr_reg(2, 8'ha8 | 8'(k != 0));
         wr_reg(0, 8'h24 | 8'(k == 2));
         pulse_timeout();
         chk("switch clear", 8'(k == 0), 8'(isw_clr));
         if (k != 1) m[0][2] = 1'b0;
         rd_reg(0);
      end
      wr_reg(1, i_host.phase_byte(1'b0, 4'h4));
      @(posedge clk_in) reg_reset_in <= 1'b1;
      @(posedge clk_in) reg_reset_in <= 1'b0;
      m = '{RST_CONVERTER_MODE_CONTROL, RST_PHASE_AND_TRANSITION_CONTROL, RST_PRECHARGE_TIMING_CONTROL};
      for (int i = 0; i < 3; i++) rd_reg(i);
      outs();
      wr_reg(0, 8'h20);
      wr_reg(2, 8'ha1);
      wr_reg(0, 8'h24);
      n = 0;
      seen = 1'b0;
      while (conv_on !== 1'b1 && n < 60000) begin
         @(posedge clk_in);
         n++;
         seen = seen | pre;
      end
      chk("precharge seen", 8'h01, 8'(seen));
      chk("precharge length", 8'h01, 8'(n >= 49990 && n <= 50020));
      chk("running", 8'h01, 8'(conv_on));
      pulse_timeout();
      repeat (2) @(posedge clk_in);
      #1 chk("kept running", 8'h01, 8'(conv_on));
      chk("bypass mode", 8'(MODE_FWD_BYPASS), 8'(mode));
      rd_reg(0);
      // short error only stops the converter in bypass; halving keeps running
      wr_reg(0, 8'h25);
      @(posedge clk_in) oshort <= 1'b1;
      @(posedge clk_in) oshort <= 1'b0;
      #1 chk("short ignored", 8'h01, 8'(conv_on));
      wr_reg(0, 8'h24);
      @(posedge clk_in) overvoltage_fault <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1 chk("fault stop", 8'h00, 8'(conv_on));
      chk("recovery", 8'h01, 8'(rpend));
      complete_run();
   end
endmodule
`default_nettype wire
